// file: design/cpsfc_top.sv
/*
 Control and fault logic of a dual-channel card socket power switch.
 Assumes analog comparators deliver asynchronous flags and APB software.
*/
`timescale 1ns/1ps
module cpsfc_top (
  // Clock and reset.
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // APB slave.
  input  wire logic [7:0]            paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic                       irq,
  // Management pins.
  input  wire logic                  suspendSelectInput,
  input  wire logic                  addrSelectIn,
  input  wire logic                  smbClkIn,
  input  wire logic                  smbDataIn,
  output logic                       smbDataOut,
  output logic                       smbDataOe,
  output logic                       faultAlertOutput,
  output logic                       faultAlertOe,
  // Comparator flags.
  input  wire logic                  tempTripIn,
  input  wire logic                  tempReleaseIn,
  input  wire logic                  highRailInputLow,
  input  wire logic                  lowRailInputLow,
  input  wire logic                  logicSupplyLow,
  input  wire logic [3:0]            overCurrentIn,
  input  wire logic [1:0]            progSupplyInputAbove8,
  input  wire logic [1:0]            progSupplyInputBelow2,
  // Switch drives, index is channel; softStart index is switch (cards 0-1, programming 2-3).
  output logic      [1:0]            cardSupplyOutHigh,
  output logic      [1:0]            cardSupplyOutLow,
  output logic      [1:0]            cardSupplyOutGnd,
  output logic      [1:0]            progSupplyOutPgm,
  output logic      [1:0]            progSupplyOutCard,
  output logic      [1:0]            progSupplyOutGnd,
  output logic      [3:0]            softStart,
  output cpsfc_pkg::cpsfc_mode_t     opMode
);
  import cpsfc_pkg::*;
  // ****************************************************************
  // Input synchronisation and command receiver.
  // ****************************************************************
  logic [SYNC_W-1:0] sv;
  logic [3:0]        oc;
  cpsfc_cmd_if cmdBus ();
  cpsfc_sync #(.W(SYNC_W)) uSync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .asyncIn ({progSupplyInputBelow2, progSupplyInputAbove8, overCurrentIn,
               logicSupplyLow, lowRailInputLow, highRailInputLow,
               tempReleaseIn, tempTripIn, smbDataIn, smbClkIn,
               addrSelectIn, suspendSelectInput}),
    .syncOut (sv)
  );
  logic rxOe;
  cpsfc_smbus_rx uRx (
    .clk_sys (clk_sys),
    .rst     (rst),
    .scl     (sv[IN_SCL]),
    .sda     (sv[IN_SDA]),
    .adrSel  (sv[IN_ADR]),
    .sdaOe   (rxOe),
    .cmd     (cmdBus.rx)
  );
  assign oc = sv[IN_OC +: 4];
  // ****************************************************************
  // State.
  // ****************************************************************
  logic [7:0]      normReg [2];
  logic [7:0]      normNext [2];
  logic [7:0]      suspReg [2];
  logic [7:0]      suspNext [2];
  logic [7:0]      applied [2];
  logic [8:0]      offReg [4];
  logic [8:0]      offNext [4];
  logic [8:0]      runReg [4];
  logic [8:0]      runNext [4];
  logic [3:0]      persist;
  logic [3:0]      swOn, swOnNext;
  logic [1:0]      armedReg, armedNext;
  logic            thermReg, thermNext;
  logic [ST_W-1:0] statusReg, statusNext, statusSet, statusClr;
  logic [ST_W-1:0] enReg, enNext;
  logic [1:0]      cHiReg, cHiNext, cLoReg, cLoNext, cGndReg, cGndNext;
  logic [1:0]      pPgReg, pPgNext, pCdReg, pCdNext, pGndReg, pGndNext;
  logic [3:0]      softReg, softNext;
  cpsfc_mode_t     modeReg, modeNext;
  logic            alertReg, alertNext;
  logic            irqReg, irqNext;
  logic            sdaOeReg;
  logic            limiting, uvAny;
  logic            cFl, pFl, cUv, pUv;
  logic [31:0]     rdataReg, rdataNext;
  logic            readyReg, readyNext, errReg, errNext;
  logic            apbDone, mapped;
  // ****************************************************************
  // Latches and applied setting.
  // ****************************************************************
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      normNext[c] = normReg[c];
      suspNext[c] = suspReg[c];
      if (cmdBus.cmdValid && (cmdBus.cmdChanB == c[0])) begin
        if (cmdBus.cmdByte[B_OPSEL]) begin
          normNext[c] = cmdBus.cmdByte;
        end else begin
          suspNext[c] = cmdBus.cmdByte;
        end
      end
      applied[c] = sv[IN_SUSP] ? normReg[c] : suspReg[c];
    end
  end
  // ****************************************************************
  // Fault detection and switch drive.
  // ****************************************************************
  always_comb begin
    thermNext = thermReg;
    if (sv[IN_TTRP]) begin
      thermNext = 1'b1;
    end else if (sv[IN_TREL]) begin
      thermNext = 1'b0;
    end
    limiting = 1'b0;
    for (int i = 0; i < 4; i++) begin
      runNext[i] = 9'h000;
      if (oc[i]) begin
        runNext[i] = (runReg[i] == OC_LATCH_CYC) ? runReg[i]
          : runReg[i] + 9'h001;
      end
      persist[i] = oc[i] && (runReg[i] == OC_LATCH_CYC);
      offNext[i] = 9'h000;
      if (offReg[i] != 9'h000) begin
        offNext[i] = offReg[i] - 9'h001;
      end else if (oc[i] && swOn[i]) begin
        offNext[i] = OC_OFF_CYC;
      end
      limiting = limiting | oc[i] | (offReg[i] != 9'h000);
    end
    uvAny = 1'b0;
    for (int c = 0; c < 2; c++) begin
      armedNext[c] = armedReg[c];
      if (sv[IN_P8 + c]) begin
        armedNext[c] = 1'b1;
      end else if (sv[IN_P2 + c]) begin
        armedNext[c] = 1'b0;
      end
      cUv = applied[c][B_CARD_ON] && !applied[c][B_CARD_FL] &&
        (applied[c][B_CARD_LO] ? sv[IN_LRLO] : sv[IN_HRLO]);
      pUv = applied[c][B_PROG_ON] && !applied[c][B_PROG_FL] &&
        applied[c][B_PROG_PG] && !armedNext[c];
      uvAny = uvAny | cUv | pUv;
      cFl = sv[IN_LGLO] || thermNext || applied[c][B_CARD_FL] || cUv;
      pFl = sv[IN_LGLO] || thermNext || applied[c][B_PROG_FL] || pUv;
      cGndNext[c] = !cFl && !applied[c][B_CARD_ON];
      pGndNext[c] = !pFl && !applied[c][B_PROG_ON];
      cHiNext[c] = !cFl && applied[c][B_CARD_ON] && !applied[c][B_CARD_LO]
        && (offReg[c] == 9'h000);
      cLoNext[c] = !cFl && applied[c][B_CARD_ON] && applied[c][B_CARD_LO]
        && (offReg[c] == 9'h000);
      pPgNext[c] = !pFl && applied[c][B_PROG_ON] && applied[c][B_PROG_PG]
        && (offReg[c + 2] == 9'h000);
      pCdNext[c] = !pFl && applied[c][B_PROG_ON] && !applied[c][B_PROG_PG]
        && (offReg[c + 2] == 9'h000);
    end
    swOnNext = {pPgNext[1] | pCdNext[1], pPgNext[0] | pCdNext[0],
                cHiNext[1] | cLoNext[1], cHiNext[0] | cLoNext[0]};
    softNext = swOnNext & ~swOn;
    if (sv[IN_LGLO]) begin
      modeNext = MODE_SHUTDOWN;
    end else if (swOnNext == 4'h0) begin
      modeNext = MODE_STANDBY;
    end else begin
      modeNext = MODE_NORMAL;
    end
    alertNext = !applied[0][B_MASK] && (limiting || uvAny || thermNext ||
      statusReg[ST_OCA] || statusReg[ST_OCB]);
  end
  // ****************************************************************
  // Register bus and interrupts.
  // ****************************************************************
  always_comb begin
    readyNext = psel && penable && !readyReg;
    apbDone   = psel && penable && readyReg;
    mapped = (paddr == ADDR_APPLIED) || (paddr == ADDR_LATCH) ||
      (paddr == ADDR_STATUS) || (paddr == ADDR_IRQ_EN) ||
      (paddr == ADDR_IRQ_CLR);
    errNext   = readyNext && !mapped;
    rdataNext = 32'h0000_0000;
    if (readyNext && !pwrite) begin
      case (paddr)
        ADDR_APPLIED: rdataNext = {14'h0000, modeReg, applied[1],
                                   applied[0]};
        ADDR_LATCH:   rdataNext = {suspReg[1], suspReg[0], normReg[1],
                                   normReg[0]};
        ADDR_STATUS:  rdataNext = {27'h000_0000, statusReg};
        ADDR_IRQ_EN:  rdataNext = {27'h000_0000, enReg};
        default:      rdataNext = 32'h0000_0000;
      endcase
    end
    enNext    = enReg;
    statusClr = '0;
    if (apbDone && pwrite && paddr == ADDR_IRQ_EN) begin
      enNext = pwdata[ST_W-1:0];
    end
    if (apbDone && pwrite && paddr == ADDR_IRQ_CLR) begin
      statusClr = pwdata[ST_W-1:0];
    end
    statusSet = '0;
    statusSet[ST_OCA] = persist[0] | persist[2];
    statusSet[ST_OCB] = persist[1] | persist[3];
    statusSet[ST_THM] = thermNext & ~thermReg;
    statusSet[ST_UV]  = uvAny;
    statusSet[ST_CMD] = cmdBus.cmdValid;
    statusNext = (statusReg & ~statusClr) | statusSet;
    irqNext    = |(statusReg & enReg);
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int c = 0; c < 2; c++) begin
        normReg[c] <= LATCH_RST;
        suspReg[c] <= LATCH_RST;
      end
      for (int i = 0; i < 4; i++) begin
        offReg[i] <= 9'h000;
        runReg[i] <= 9'h000;
      end
      armedReg  <= 2'h0;
      thermReg  <= 1'b0;
      statusReg <= '0;
      enReg     <= '0;
      cHiReg    <= 2'h0;
      cLoReg    <= 2'h0;
      cGndReg   <= 2'h0;
      pPgReg    <= 2'h0;
      pCdReg    <= 2'h0;
      pGndReg   <= 2'h0;
      swOn      <= 4'h0;
      softReg   <= 4'h0;
      modeReg   <= MODE_SHUTDOWN;
      alertReg  <= 1'b0;
      irqReg    <= 1'b0;
      sdaOeReg  <= 1'b0;
      rdataReg  <= 32'h0000_0000;
      readyReg  <= 1'b0;
      errReg    <= 1'b0;
    end else begin
      normReg   <= normNext;
      suspReg   <= suspNext;
      offReg    <= offNext;
      runReg    <= runNext;
      armedReg  <= armedNext;
      thermReg  <= thermNext;
      statusReg <= statusNext;
      enReg     <= enNext;
      cHiReg    <= cHiNext;
      cLoReg    <= cLoNext;
      cGndReg   <= cGndNext;
      pPgReg    <= pPgNext;
      pCdReg    <= pCdNext;
      pGndReg   <= pGndNext;
      swOn      <= swOnNext;
      softReg   <= softNext;
      modeReg   <= modeNext;
      alertReg  <= alertNext;
      irqReg    <= irqNext;
      sdaOeReg  <= rxOe;
      rdataReg  <= rdataNext;
      readyReg  <= readyNext;
      errReg    <= errNext;
    end
  end
  assign prdata            = rdataReg;
  assign pready            = readyReg;
  assign pslverr           = errReg;
  assign irq               = irqReg;
  assign smbDataOut        = 1'b0;
  assign smbDataOe         = sdaOeReg;
  assign faultAlertOutput  = 1'b0;
  assign faultAlertOe      = alertReg;
  assign cardSupplyOutHigh = cHiReg;
  assign cardSupplyOutLow  = cLoReg;
  assign cardSupplyOutGnd  = cGndReg;
  assign progSupplyOutPgm  = pPgReg;
  assign progSupplyOutCard = pCdReg;
  assign progSupplyOutGnd  = pGndReg;
  assign softStart         = softReg;
  assign opMode            = modeReg;
  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [11:0] allOut;
  assign allOut = {cHiReg, cLoReg, cGndReg, pPgReg, pCdReg, pGndReg};
  AST_APPLY_NORM: assert property (sv[IN_SUSP] && !sv[IN_LGLO] &&
    !sv[IN_TTRP] && !thermReg && normReg[0][6:4] == 3'b000
    |=> cGndReg[0]) else $error("normal latch not applied");
  AST_ALERT_THERM: assert property (thermReg && !sv[IN_TREL]
    && !applied[0][B_MASK] |=> faultAlertOe)
    else $error("alert missing on thermal");
  AST_OPEN_DRAIN: assert property (faultAlertOutput == 1'b0)
    else $error("alert driven high");
  AST_NORMAL_CONN: assert property (modeReg == MODE_NORMAL
    |-> swOn != 4'h0) else $error("normal with nothing on");
  AST_STANDBY: assert property (modeReg == MODE_STANDBY
    |-> (cHiReg | cLoReg | pPgReg | pCdReg) == 2'h0)
    else $error("rail connected in standby");
  AST_SHUTDOWN: assert property (sv[IN_LGLO]
    |=> allOut == 12'h000 && modeReg == MODE_SHUTDOWN)
    else $error("output active in shutdown");
  AST_OC_OFF: assert property (offReg[0] != 9'h000
    |=> (cHiReg[0] | cLoReg[0]) == 1'b0)
    else $error("switch on during retry");
  AST_OC_LATCH: assert property (oc[0] && runReg[0] == OC_LATCH_CYC
    |=> statusReg[ST_OCA] [*2]) else $error("overcurrent not latched");
  AST_THERM_OFF: assert property ($rose(sv[IN_TTRP])
    |=> allOut == 12'h000) else $error("switch left on hot");
  AST_THERM_REL: assert property ($fell(thermReg) |-> $past(sv[IN_TREL])
    && !$past(sv[IN_TTRP])) else $error("thermal released early");
  AST_UV_FLOAT: assert property (applied[0][6:4] == 3'b100 && sv[IN_HRLO]
    |=> !cHiReg[0] && !cGndReg[0]) else $error("dead rail used");
  AST_PROG_ARM: assert property (!armedReg[0] && !sv[IN_P8]
    |=> !pPgReg[0]) else $error("program switch not armed");
  AST_LATCH_OP: assert property (cmdBus.cmdValid && cmdBus.cmdByte[7]
    && !cmdBus.cmdChanB |=> normReg[0] == $past(cmdBus.cmdByte))
    else $error("operation latch not written");
  AST_FLOAT_PRIO: assert property (applied[1][B_CARD_FL]
    |=> cHiReg[1] == 1'b0 && cLoReg[1] == 1'b0 && cGndReg[1] == 1'b0)
    else $error("float bit ignored");
  AST_MASK: assert property (applied[0][B_MASK] |=> !faultAlertOe)
    else $error("alert not masked");
  CV_THERM: cover property ($rose(thermReg) ##[1:100] $fell(thermReg));
  CV_OCLATCH: cover property ($rose(statusReg[ST_OCA]));
  CV_CMD: cover property (cmdBus.cmdValid);
  CV_STANDBY: cover property (modeReg == MODE_STANDBY ##1
    modeReg == MODE_NORMAL);
endmodule : cpsfc_top

// file: design/cpsfc_pkg.sv
/*
 Constants, types and register map of the card power switch control block.
 Assumes a 125 MHz system clock and comparator flags from the analog side.
*/
// Functional notes
// - Suspend input high applies normal latch, else suspend.
// - Alert low on limiting, lockout or thermal.
// - Alert pin is open-drain, pull or release.
// - Modes are normal, standby and shutdown only.
// - Standby: outputs grounded or floating, never on rails.
// - Logic supply low enters shutdown, outputs float.
// - Overcurrent turns switch off briefly, then ramps on.
// - Overcurrent beyond 2 us latches alert low.
// - Above 150 C open every switch, assert alert.
// - Release thermal trip only below 130 C.
// - Rail below 1.5 V floats channels using it.
// - Programming switch arms above 8 V, drops below 2 V.
// - Logic supply below 2.3 V floats all outputs.
// - Address pin picks the channel write address pair.
// - Command MSB picks operation or suspend latch.
// - Float bit overrides the on bit per output.
// - Channel A mask bit suppresses alert for both.
package cpsfc_pkg;
  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int CLK_MHZ     = 125;
  localparam int OC_OFF_NS   = 1000;
  localparam int OC_LATCH_NS = 2000;
  localparam logic [8:0] OC_OFF_CYC   = 9'((OC_OFF_NS * CLK_MHZ + 999) / 1000);
  localparam logic [8:0] OC_LATCH_CYC = 9'((OC_LATCH_NS * CLK_MHZ) / 1000);
  // ****************************************************************
  // Command byte fields.
  // ****************************************************************
  localparam int B_OPSEL   = 7;
  localparam int B_CARD_ON = 6;
  localparam int B_CARD_LO = 5;
  localparam int B_CARD_FL = 4;
  localparam int B_PROG_ON = 3;
  localparam int B_PROG_PG = 2;
  localparam int B_PROG_FL = 1;
  localparam int B_MASK    = 0;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [4:0] CHAN_ADDR_BASE = 5'h14;
  // ****************************************************************
  // Synchroniser bit positions.
  // ****************************************************************
  localparam int IN_SUSP = 0;
  localparam int IN_ADR  = 1;
  localparam int IN_SCL  = 2;
  localparam int IN_SDA  = 3;
  localparam int IN_TTRP = 4;
  localparam int IN_TREL = 5;
  localparam int IN_HRLO = 6;
  localparam int IN_LRLO = 7;
  localparam int IN_LGLO = 8;
  localparam int IN_OC   = 9;
  localparam int IN_P8   = 13;
  localparam int IN_P2   = 15;
  localparam int SYNC_W  = 17;
  // ****************************************************************
  // Register map and status bits.
  // ****************************************************************
  localparam logic [7:0] ADDR_APPLIED = 8'h00;
  localparam logic [7:0] ADDR_LATCH   = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
  localparam int ST_OCA = 0;
  localparam int ST_OCB = 1;
  localparam int ST_THM = 2;
  localparam int ST_UV  = 3;
  localparam int ST_CMD = 4;
  localparam int ST_W   = 5;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_STANDBY, MODE_SHUTDOWN}
    cpsfc_mode_t;
  typedef enum logic [2:0] {RX_IDLE, RX_ADDR, RX_ACK1, RX_DATA, RX_ACK2,
    RX_WAIT} cpsfc_rx_t;
endpackage : cpsfc_pkg

// file: design/cpsfc_cmd_if.sv
/*
 Carrier for a received channel command.
 Assumes one clock domain shared by sender and receiver.
*/
`timescale 1ns/1ps
interface cpsfc_cmd_if;
  logic       cmdValid;
  logic       cmdChanB;
  logic [7:0] cmdByte;
  modport rx (output cmdValid, output cmdChanB, output cmdByte);
  modport core (input cmdValid, input cmdChanB, input cmdByte);
endinterface : cpsfc_cmd_if

// file: design/cpsfc_sync.sv
/*
 Two-flop synchroniser of a vector of asynchronous levels.
 Assumes each bit is an independent level.
*/
`timescale 1ns/1ps
module cpsfc_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Levels.
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] stage1Reg;
  logic [W-1:0] stage1Next;
  logic [W-1:0] stage2Reg;
  logic [W-1:0] stage2Next;
  always_comb begin
    stage1Next = asyncIn;
    stage2Next = stage1Reg;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage1Reg <= '0;
      stage2Reg <= '0;
    end else begin
      stage1Reg <= stage1Next;
      stage2Reg <= stage2Next;
    end
  end
  assign syncOut = stage2Reg;
endmodule : cpsfc_sync

// file: design/cpsfc_smbus_rx.sv
/*
 Write-only two-wire slave: address, one command byte, stop.
 Assumes clock and data already synchronised to clk_sys.
*/
`timescale 1ns/1ps
module cpsfc_smbus_rx
  import cpsfc_pkg::*;
(
  // Clock and reset.
  input  wire logic   clk_sys,
  input  wire logic   rst,
  // Bus lines and address pin.
  input  wire logic   scl,
  input  wire logic   sda,
  input  wire logic   adrSel,
  output logic        sdaOe,
  // Received command.
  cpsfc_cmd_if.rx     cmd
);
  cpsfc_rx_t  stateReg, stateNext;
  logic [3:0] bitReg, bitNext;
  logic [7:0] shiftReg, shiftNext;
  logic       chanReg, chanNext;
  logic       oeReg, oeNext;
  logic       validReg, validNext;
  logic       sclPrev, sdaPrev;
  logic       sclRise, sclFall, startCond, stopCond, match;
  always_comb begin
    sclRise   = scl & ~sclPrev;
    sclFall   = ~scl & sclPrev;
    startCond = scl & sclPrev & sdaPrev & ~sda;
    stopCond  = scl & sclPrev & ~sdaPrev & sda;
    match = (shiftReg[7:3] == CHAN_ADDR_BASE) && (shiftReg[2] == adrSel)
      && !shiftReg[0];
    stateNext = stateReg;
    bitNext   = bitReg;
    shiftNext = shiftReg;
    chanNext  = chanReg;
    oeNext    = oeReg;
    validNext = 1'b0;
    if (startCond) begin
      stateNext = RX_ADDR;
      bitNext   = 4'h0;
      oeNext    = 1'b0;
    end else if (stopCond) begin
      validNext = (stateReg == RX_WAIT);
      stateNext = RX_IDLE;
      oeNext    = 1'b0;
    end else begin
      if (sclRise && (stateReg == RX_ADDR || stateReg == RX_DATA)) begin
        shiftNext = {shiftReg[6:0], sda};
        bitNext   = bitReg + 4'h1;
      end
      case (stateReg)
        RX_ADDR: if (sclFall && bitReg == 4'h8) begin
          stateNext = match ? RX_ACK1 : RX_IDLE;
          oeNext    = match;
          chanNext  = shiftReg[1];
        end
        RX_ACK1: if (sclFall) begin
          stateNext = RX_DATA;
          bitNext   = 4'h0;
          oeNext    = 1'b0;
        end
        RX_DATA: if (sclFall && bitReg == 4'h8) begin
          stateNext = RX_ACK2;
          oeNext    = 1'b1;
        end
        RX_ACK2: if (sclFall) begin
          stateNext = RX_WAIT;
          oeNext    = 1'b0;
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stateReg <= RX_IDLE;
      bitReg   <= 4'h0;
      shiftReg <= 8'h00;
      chanReg  <= 1'b0;
      oeReg    <= 1'b0;
      validReg <= 1'b0;
      sclPrev  <= 1'b1;
      sdaPrev  <= 1'b1;
    end else begin
      stateReg <= stateNext;
      bitReg   <= bitNext;
      shiftReg <= shiftNext;
      chanReg  <= chanNext;
      oeReg    <= oeNext;
      validReg <= validNext;
      sclPrev  <= scl;
      sdaPrev  <= sda;
    end
  end
  assign sdaOe        = oeReg;
  assign cmd.cmdValid = validReg;
  assign cmd.cmdChanB = chanReg;
  assign cmd.cmdByte  = shiftReg;
endmodule : cpsfc_smbus_rx

// file: verification/cpsfc_smb_host.sv
/* Two-wire host model: start, address, one byte, stop.
 Assumes the bench resolves the open-drain data line. */
`timescale 1ns/1ps
module cpsfc_smb_host (
  // Wire levels.
  output logic      scl,
  output logic      sdaOe,
  input  wire logic sda
);
  initial {scl, sdaOe} = 2'h2;
  task automatic send(input logic [6:0] a, input logic [7:0] d,
                      output logic ack);
    logic [17:0] f;
    f = {a, 1'h0, 1'h1, d, 1'h1};
    ack = 1'h1;
    sdaOe = 1'h1;
    #80 scl = 1'h0;
    for (int i = 17; i >= 0; i--) begin
      #40 sdaOe = !f[i];
      #40 scl = 1'h1;
      #40 if (i % 9 == 0) ack &= !sda;
      #40 scl = 1'h0;
    end
    #40 sdaOe = 1'h1;
    #40 scl = 1'h1;
    #80 sdaOe = 1'h0;
    #400;
  endtask : send
endmodule : cpsfc_smb_host

// file: verification/tb.sv
/* Self-checking bench of the card power switch control block.
 Assumes the host model and an 8 ns clock. */
`timescale 1ns/1ps
module tb;
  import cpsfc_pkg::*;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, irq, err;
  logic smbClkIn, smbDataOut, smbDataOe, hostOe, ack, faultAlertOutput;
  logic faultAlertOe, suspendSelectInput, addrSelectIn, tempTripIn;
  logic tempReleaseIn, highRailInputLow, lowRailInputLow, logicSupplyLow;
  logic [7:0] paddr, latN [2], latS [2];
  logic [31:0] pwdata, prdata, q;
  logic [3:0] overCurrentIn, softStart;
  logic [1:0] progSupplyInputAbove8, progSupplyInputBelow2;
  logic [1:0] cardSupplyOutHigh, cardSupplyOutLow, cardSupplyOutGnd;
  logic [1:0] progSupplyOutPgm, progSupplyOutCard, progSupplyOutGnd;
  cpsfc_mode_t opMode;
  int n_errors = 0, samples_checked = 0, t;
  wire smbDataIn = !(hostOe | smbDataOe);
  cpsfc_top dut (.*);
  cpsfc_smb_host host (.scl(smbClkIn), .sdaOe(hostOe), .sda(smbDataIn));
  function automatic logic [31:0] card(input logic [7:0] b);
    if (b[B_CARD_FL]) return 0;
    if (!b[B_CARD_ON]) return 1;
    return b[B_CARD_LO] ? 2 : 4;
  endfunction : card
  function automatic logic [31:0] seen(input int c);
    return 32'({cardSupplyOutHigh[c], cardSupplyOutLow[c],
                cardSupplyOutGnd[c]});
  endfunction : seen
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    tick(1);
    penable <= 1'h1;
    do tick(1); while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
    tick(1);
  endtask : apb
  task automatic wr(input logic ch, input logic [7:0] b, input logic ok);
    host.send({CHAN_ADDR_BASE, addrSelectIn ^ !ok, ch}, b, ack);
    chk(32'(ack), 32'(ok));
    if (ok && b[B_OPSEL]) latN[ch] = b;
    if (ok && !b[B_OPSEL]) latS[ch] = b;
    tick(8);
  endtask : wr
  task automatic stop_test;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = !clk_sys;
  end
  initial begin
    #400_000;
    n_errors++;
    stop_test();
  end
  initial begin
    {rst, suspendSelectInput, tempReleaseIn, psel, penable, pwrite} = 6'h38;
    {addrSelectIn, tempTripIn, highRailInputLow, lowRailInputLow} = '0;
    {logicSupplyLow, paddr, pwdata, overCurrentIn} = '0;
    {progSupplyInputAbove8, progSupplyInputBelow2} = 4'hC;
    latN = '{8'h00, 8'h00};
    latS = latN;
    void'($urandom(32'h0000_e634));
    tick(12);
    rst <= 1'h0;
    tick(3);
    for (int i = 0; i < 10; i++) begin
      addrSelectIn <= 1'($urandom);
      tick(4);
      wr(1'($urandom), 8'($urandom), i % 4 != 3);
      suspendSelectInput <= 1'($urandom);
      tick(4);
      for (int c = 0; c < 2; c++)
        chk(seen(c), card(suspendSelectInput ? latN[c] : latS[c]));
    end
    $display("random done");
    suspendSelectInput <= 1'h1;
    wr(0, 8'hC0, 1);
    {tempTripIn, tempReleaseIn} <= 2'h2;
    tick(4);
    chk(seen(0) | seen(1), 0);
    chk(32'(faultAlertOe), 1);
    tempTripIn <= 1'h0;
    tick(6);
    chk(seen(0), 0);
    tempReleaseIn <= 1'h1;
    tick(6);
    chk(seen(0), 4);
    wr(0, 8'hC1, 1);
    tempTripIn <= 1'h1;
    tick(4);
    chk(32'(faultAlertOe), 0);
    tempTripIn <= 1'h0;
    wr(0, 8'hC0, 1);
    highRailInputLow <= 1'h1;
    tick(4);
    chk((seen(0) << 1) | 32'(faultAlertOe), 1);
    highRailInputLow <= 1'h0;
    $display("faults done");
    tick(8);
    overCurrentIn <= 4'h1;
    tick(5);
    chk(32'({cardSupplyOutHigh[0], faultAlertOe}), 1);
    overCurrentIn <= 4'h0;
    t = 0;
    while (softStart[0] !== 1'h1 && ++t < 200) tick(1);
    chk(32'(t < 200), 1);
    tick(4);
    apb(0, ADDR_STATUS, 0);
    chk(32'({q[ST_OCA], faultAlertOe, cardSupplyOutHigh[0]}), 1);
    overCurrentIn <= 4'h1;
    tick(300);
    overCurrentIn <= 4'h0;
    tick(150);
    apb(0, ADDR_STATUS, 0);
    chk(32'({q[ST_OCA], faultAlertOe}), 3);
    apb(1, ADDR_IRQ_EN, 1);
    tick(2);
    chk(32'(irq), 1);
    apb(1, ADDR_IRQ_EN, 0);
    tick(2);
    chk(32'(irq), 0);
    apb(1, ADDR_IRQ_EN, 1);
    apb(1, ADDR_IRQ_CLR, 1);
    tick(4);
    chk(32'({irq, faultAlertOe}), 0);
    apb(0, 8'h40, 0);
    chk(32'(err), 1);
    logicSupplyLow <= 1'h1;
    tick(4);
    chk(32'(opMode), MODE_SHUTDOWN);
    chk(32'({cardSupplyOutHigh, cardSupplyOutLow, cardSupplyOutGnd,
       progSupplyOutPgm, progSupplyOutCard, progSupplyOutGnd}), 0);
    $display("power done");
    stop_test();
  end
endmodule : tb
